// ### hw/cmbi_block_fill.sv
// connection memory block fill engine with its two host registers
// host request comes from logic on clk; memory datapath and TDM drivers sit outside
`timescale 1ns/1ns
module cmbi_block_fill #(
   parameter int CM_DEPTH = 24576,
   parameter int LANES    = 4
) (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire cmbi_pkg::cmbi_req_type host_req,
   output logic                   host_ack,
   output logic                   bus_fault_response,
   output logic [31:0]            host_rdata,
   output logic                   cm_we,
   output logic [$clog2(CM_DEPTH/LANES)-1:0] cm_group,
   output logic [31:0]            cm_wdata,
   output logic                   tdm_hiz
);
   import cmbi_pkg::*;

   localparam int GROUPS = CM_DEPTH / LANES;
   localparam int GW     = $clog2(GROUPS);
   localparam logic [GW-1:0] LAST_GROUP = GW'(GROUPS - 1);

   cmbi_state_type state;
   cmbi_state_type next_state;
   logic [GW-1:0]  group;
   logic [GW-1:0]  next_group;
   logic [31:0]    fill_word;
   logic [31:0]    next_fill_word;
   logic           pwr_init;
   logic           next_pwr_init;
   logic [31:0]    pattern;
   logic [31:0]    next_pattern;
   logic           next_cm_we;
   logic           next_tdm_hiz;
   cmbi_rsp_type   rsp;
   cmbi_rsp_type   next_rsp;

   logic           busy;
   logic           last;
   logic           wr_pattern;
   logic           wr_key;
   logic           mem_hit;

   ////////////////////////////////////////////////////////////////////////////////
   // decode of the host request
   assign busy       = (state == ST_FILL);
   assign last       = (group == LAST_GROUP);
   assign wr_pattern = host_req.valid && host_req.write && host_req.addr == ADDR_PATTERN;
   assign wr_key     = host_req.valid && host_req.write && host_req.addr == ADDR_START
                       && host_req.wdata == START_KEY;
   assign mem_hit    = host_req.valid && !host_req.addr[MEM_SEL_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // fill engine next state; one group of LANES words per clock keeps the pass near 120 us
   always_comb begin
      next_state     = state;
      next_group     = group;
      next_fill_word = fill_word;
      next_pwr_init  = pwr_init;
      case (state)
         ST_IDLE: begin
            if (wr_key) begin
               next_state     = ST_FILL;
               next_group     = '0;
               next_fill_word = pattern;           // snapshot, later writes do not reach it
            end
         end
         ST_FILL: begin
            // a key write here is simply not looked at
            if (last) begin
               next_state    = ST_IDLE;
               next_pwr_init = 1'b0;
            end else begin
               next_group = GW'(group + 1'b1);
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      next_cm_we   = (next_state == ST_FILL);
      next_tdm_hiz = (next_state == ST_FILL);
   end

   // reset lands straight in a fill with a zero word: that is the power-up clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state     <= ST_FILL;
         group     <= '0;
         fill_word <= PATTERN_RESET;
         pwr_init  <= 1'b1;
         cm_we     <= 1'b1;
         tdm_hiz   <= 1'b1;
      end else begin
         state     <= next_state;
         group     <= next_group;
         fill_word <= next_fill_word;
         pwr_init  <= next_pwr_init;
         cm_we     <= next_cm_we;
         tdm_hiz   <= next_tdm_hiz;
      end
   end

   // write port mirrors the engine registers directly
   assign cm_group = group;
   assign cm_wdata = fill_word;

   ////////////////////////////////////////////////////////////////////////////////
   // host registers and answer; every request is answered on the next clock
   always_comb begin
      next_pattern = pattern;
      next_rsp     = '0;                          // unused status bits read zero
      if (wr_pattern) begin
         next_pattern = host_req.wdata;
      end
      if (host_req.valid) begin
         next_rsp.ack = 1'b1;
         if (mem_hit && busy) begin
            next_rsp.fault = 1'b1;
         end else if (!host_req.write) begin
            case (host_req.addr)
               ADDR_PATTERN: begin
                  next_rsp.rdata = pattern;
               end
               ADDR_START: begin
                  next_rsp.rdata[STAT_BUSY_BIT] = busy;
                  next_rsp.rdata[STAT_PWR_BIT]  = pwr_init;
               end
               default: begin
                  next_rsp.rdata = '0;            // memory data comes from the datapath
               end
            endcase
         end
      end
   end

   // pattern clears at reset; the power-up pass writes the zero that fill_word loads at reset
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pattern <= PATTERN_RESET;
         rsp     <= '0;
      end else begin
         pattern <= next_pattern;
         rsp     <= next_rsp;
      end
   end

   assign host_ack           = rsp.ack;
   assign bus_fault_response = rsp.fault;
   assign host_rdata         = rsp.rdata;

   ////////////////////////////////////////////////////////////////////////////////
   // checks; a fill-length counter helps bound the pass
   logic [15:0] fill_len;
   logic [15:0] next_fill_len;

   // busy-cycle count; clears whenever the engine idles so each pass is measured alone
   always_comb begin
      next_fill_len = busy ? fill_len + 16'h0001 : 16'h0000;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fill_len <= '0;
      end else begin
         fill_len <= next_fill_len;
      end
   end

   property p_pattern_write;
      @(posedge clk) disable iff (reset)
      wr_pattern |=> pattern == $past(host_req.wdata);
   endproperty
   a_pattern_write: assert property (p_pattern_write) else $error("pattern not stored");

   property p_fill_length;
      @(posedge clk) disable iff (reset)
      fill_len <= 16'(GROUPS);
   endproperty
   a_fill_length: assert property (p_fill_length) else $error("fill runs too long");

   property p_powerup_zero;
      @(posedge clk) disable iff (reset)
      (cm_we && pwr_init) |-> cm_wdata == PATTERN_RESET;
   endproperty
   a_powerup_zero: assert property (p_powerup_zero) else $error("power-up fill not zero");

   property p_word_stable;
      @(posedge clk) disable iff (reset)
      (busy && !last) |=> $stable(fill_word);
   endproperty
   a_word_stable: assert property (p_word_stable) else $error("fill word changed");

   property p_key_starts;
      @(posedge clk) disable iff (reset)
      (!busy && wr_key) |=> busy && group == '0 && cm_wdata == $past(pattern);
   endproperty
   a_key_starts: assert property (p_key_starts) else $error("key did not start fill");

   property p_restart_ignored;
      @(posedge clk) disable iff (reset)
      (busy && !last && wr_key) |=> busy && group == $past(group) + 1'b1;
   endproperty
   a_restart_ignored: assert property (p_restart_ignored) else $error("fill restarted");

   property p_status_read;
      @(posedge clk) disable iff (reset)
      (host_req.valid && !host_req.write && host_req.addr == ADDR_START)
         |=> host_rdata == {30'h0, $past(pwr_init), $past(busy)};
   endproperty
   a_status_read: assert property (p_status_read) else $error("bad status readback");

   property p_fault;
      @(posedge clk) disable iff (reset)
      (mem_hit && busy) |=> host_ack && bus_fault_response;
   endproperty
   a_fault: assert property (p_fault) else $error("missing bus fault");

   property p_hiz;
      @(posedge clk) disable iff (reset)
      tdm_hiz == busy && cm_we == busy;
   endproperty
   a_hiz: assert property (p_hiz) else $error("TDM not high impedance");

   property p_bad_key;
      @(posedge clk) disable iff (reset)
      (!busy && host_req.valid && host_req.write && host_req.addr == ADDR_START
         && host_req.wdata != START_KEY) |=> !busy;
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("wrong key started fill");

   // a finished pass covers every group, no more and no fewer
   property p_fill_end;
      @(posedge clk) disable iff (reset)
      (fill_len != 16'h0000 && !busy) |-> fill_len == 16'(GROUPS);
   endproperty
   a_fill_end: assert property (p_fill_end) else $error("fill length wrong");

   // the pass must not run past its nominal duration plus slack at the real clock
   property p_fill_time;
      @(posedge clk) disable iff (reset)
      busy |-> fill_len < 16'(FILL_CYCLES + FILL_SLACK);
   endproperty
   a_fill_time: assert property (p_fill_time) else $error("fill exceeds time budget");

   // groups are visited in order, one per clock
   property p_group_step;
      @(posedge clk) disable iff (reset)
      (busy && !last) |=> busy && group == GW'($past(group) + 1'b1);
   endproperty
   a_group_step: assert property (p_group_step) else $error("group skipped");

   // the last group ends the pass and with it the power-up flag
   property p_fill_stops;
      @(posedge clk) disable iff (reset)
      (busy && last) |=> !busy && !pwr_init;
   endproperty
   a_fill_stops: assert property (p_fill_stops) else $error("fill did not stop");

   // the power-up flag only ever stands during a pass
   property p_pwr_in_fill;
      @(posedge clk) disable iff (reset)
      pwr_init |-> busy;
   endproperty
   a_pwr_in_fill: assert property (p_pwr_in_fill) else $error("flag outside fill");

   // pattern readback returns the stored word
   property p_pattern_read;
      @(posedge clk) disable iff (reset)
      (host_req.valid && !host_req.write && host_req.addr == ADDR_PATTERN)
         |=> host_rdata == $past(pattern);
   endproperty
   a_pattern_read: assert property (p_pattern_read) else $error("bad pattern readback");

   // only a pattern write changes the pattern; key writes leave it alone
   property p_pattern_hold;
      @(posedge clk) disable iff (reset)
      !wr_pattern |=> $stable(pattern);
   endproperty
   a_pattern_hold: assert property (p_pattern_hold) else $error("pattern changed");

   // a refused access carries no data back
   property p_fault_data;
      @(posedge clk) disable iff (reset)
      (mem_hit && busy) |=> host_rdata == 32'h00000000;
   endproperty
   a_fault_data: assert property (p_fault_data) else $error("data on refused access");

   // with no pass running a memory access is answered without a fault
   property p_mem_idle;
      @(posedge clk) disable iff (reset)
      (mem_hit && !busy) |=> host_ack && !bus_fault_response;
   endproperty
   a_mem_idle: assert property (p_mem_idle) else $error("fault while idle");

   // every request gets one answer, one clock later, and nothing else is answered
   property p_ack_match;
      @(posedge clk) disable iff (reset)
      host_ack == $past(host_req.valid);
   endproperty
   a_ack_match: assert property (p_ack_match) else $error("answer mistimed");

   // a fault never stands without its answer
   property p_fault_ack;
      @(posedge clk) disable iff (reset)
      bus_fault_response |-> host_ack;
   endproperty
   a_fault_ack: assert property (p_fault_ack) else $error("fault without answer");

   // a key arriving during a pass leaves the running word alone
   property p_key_word;
      @(posedge clk) disable iff (reset)
      (busy && wr_key) |=> $stable(fill_word);
   endproperty
   a_key_word: assert property (p_key_word) else $error("fill word replaced");

endmodule : cmbi_block_fill

// ### hw/cmbi_pkg.sv
// connection memory block fill: shared constants, types and register map
// assumes a single 50 MHz clock shared by host port and fill engine
// Functional notes
// - 32-bit read/write fill pattern register at 040288
// - fill writes pattern everywhere in about 120 us
// - power-up fill runs with cleared pattern
// - pattern writes during a fill do not affect it
// - writing start key 31415926 starts a fill
// - start request during a fill is ignored
// - status bit 0 shows fill in progress
// - status bit 1 shows power-up fill in progress
// - status bits 31 to 2 read zero
// - memory access during fill gets bus fault
// - TDM outputs high impedance during any fill
package cmbi_pkg;

   localparam int          ADDR_W          = 19;
   localparam int          DATA_W          = 32;

   // register byte addresses
   localparam logic [18:0] ADDR_PATTERN    = 19'h40288;
   localparam logic [18:0] ADDR_START      = 19'h4028C;

   // memory windows: bit 18 clear selects memory, bit 17 selects connection memory
   localparam int          MEM_SEL_BIT     = 18;
   localparam int          CM_SEL_BIT      = 17;

   // start key and status layout
   localparam logic [31:0] START_KEY       = 32'h31415926;
   localparam int          STAT_BUSY_BIT   = 0;
   localparam int          STAT_PWR_BIT    = 1;
   localparam logic [31:0] PATTERN_RESET   = 32'h00000000;

   // fill timing at 50 MHz
   localparam int          CLK_MHZ         = 50;
   localparam int          FILL_TIME_NS    = 120000;
   localparam int          FILL_CYCLES     = FILL_TIME_NS * CLK_MHZ / 1000;
   localparam int          FILL_SLACK      = 200;

   // fill engine states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_FILL = 2'b10
   } cmbi_state_type;

   // host request carried in one cycle
   typedef struct packed {
      logic              valid;
      logic              write;
      logic [18:0]       addr;
      logic [31:0]       wdata;
   } cmbi_req_type;

   // host answer, one cycle after the request
   typedef struct packed {
      logic              ack;
      logic              fault;
      logic [31:0]       rdata;
   } cmbi_rsp_type;

endpackage : cmbi_pkg

// ### bench/cmbi_host_model.sv
// host processor model: single-word accesses on the host request port
// assumes a request is taken on rising clk and answered exactly one cycle later
`timescale 1ns/1ns
module cmbi_host_model (
   input  wire logic              clk,
   output cmbi_pkg::cmbi_req_type req,
   input  wire logic              ack,
   input  wire logic              fault,
   input  wire logic [31:0]       rdata
);
   import cmbi_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////////////
   // idle until the first access
   initial req = '0;

   // one-cycle strobe; after release the address and data are inverted so a stale
   // request never looks like a fresh one
   task automatic access(input logic wr, input logic [18:0] a, input logic [31:0] d,
                         output logic [31:0] rd, output logic flt, output logic got);
      @(posedge clk) #1;
      req = '{valid: 1'h1, write: wr, addr: a, wdata: d};
      @(posedge clk) #1;
      req = '{valid: 1'h0, write: ~wr, addr: ~a, wdata: ~d};
      got = ack;
      rd  = rdata;
      flt = fault;
   endtask : access
endmodule : cmbi_host_model

// ### bench/testbench.sv
// self-checking bench for the connection memory block fill engine
// assumes a short memory (64 words, 4 lanes) so each fill lasts 16 cycles
`timescale 1ns/1ns
module testbench;
   import cmbi_pkg::*;
   logic              clk;
   logic              reset;
   cmbi_req_type      req;
   logic              ack;
   logic              fault;
   logic [31:0]       rdata;
   logic              cm_we;
   logic [3:0]        cm_group;
   logic [31:0]       cm_wdata;
   logic              tdm_hiz;
   logic [31:0]       exp_pat = 32'h0;
   logic [3:0]        grp_exp = 4'h0;
   int                we_cnt = 0;
   int                fill_left = 16;
   int                cyc = 0;
   int                n_fail = 0;
   int                tests_run = 0;
   ////////////////////////////////////////////////////////////////////////////////////////
   cmbi_block_fill #(.CM_DEPTH(64), .LANES(4)) dut_u (
      .clk(clk), .reset(reset), .host_req(req), .host_ack(ack),
      .bus_fault_response(fault), .host_rdata(rdata), .cm_we(cm_we),
      .cm_group(cm_group), .cm_wdata(cm_wdata), .tdm_hiz(tdm_hiz));
   cmbi_host_model host_u (.clk(clk), .req(req), .ack(ack), .fault(fault), .rdata(rdata));
   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one access, judged on ack, fault and read data
   task automatic acc(input logic wr, input logic [18:0] a, input logic [31:0] d,
                      input logic [31:0] erd, input logic eflt);
      logic [31:0] rd;
      logic        flt;
      logic        got;
      host_u.access(wr, a, d, rd, flt, got);
      // a key taken while idle starts a pass; one taken during a pass changes nothing
      if (wr && a == ADDR_START && d == START_KEY && fill_left == 0) begin
         fill_left = 16;
      end
      chk({31'h0, got}, 32'h1);
      chk({31'h0, flt}, {31'h0, eflt});
      chk(rd, erd);
   endtask : acc

   task automatic summarize;
      if (n_fail == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////////////////////////////////
   // fill monitor: groups in order, pattern on every write, outputs parked while filling
   // the bench's own pass length, not the design's strobe, says when writes are due
   always @(posedge clk) begin
      if (!reset) begin
         chk({31'h0, tdm_hiz}, {31'h0, (fill_left != 0)});
         chk({31'h0, cm_we}, {31'h0, (fill_left != 0)});
         if (cm_we === 1'h1) begin
            we_cnt++;
         end
         if (fill_left != 0) begin
            chk({28'h0, cm_group}, {28'h0, grp_exp});
            chk(cm_wdata, exp_pat);
            fill_left--;
            grp_exp = grp_exp + 4'h1;
         end else begin
            grp_exp = 4'h0;
         end
      end
   end

   // hang guard: all scenarios fit well inside this many cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic t_powerup;
      acc(1'h0, ADDR_START, 32'h0, 32'h3, 1'h0);
      acc(1'h0, 19'h20004, 32'h0, 32'h0, 1'h1);
      acc(1'h1, 19'h00008, 32'h1, 32'h0, 1'h1);
      repeat (20) @(posedge clk);
      acc(1'h0, ADDR_START, 32'h0, 32'h0, 1'h0);
      chk(32'(we_cnt), 32'h10);
      acc(1'h0, ADDR_PATTERN, 32'h0, PATTERN_RESET, 1'h0);
   endtask : t_powerup

   // host fill with a pattern change and a second key while running
   task automatic t_fill;
      acc(1'h1, ADDR_PATTERN, 32'hA5C30F96, 32'h0, 1'h0);
      acc(1'h0, ADDR_PATTERN, 32'h0, 32'hA5C30F96, 1'h0);
      exp_pat = 32'hA5C30F96;
      we_cnt  = 0;
      acc(1'h1, ADDR_START, START_KEY, 32'h0, 1'h0);
      acc(1'h1, ADDR_PATTERN, 32'h0000FFFF, 32'h0, 1'h0);
      acc(1'h1, ADDR_START, START_KEY, 32'h0, 1'h0);
      acc(1'h0, ADDR_START, 32'h0, 32'h1, 1'h0);
      acc(1'h1, 19'h20010, 32'h1, 32'h0, 1'h1);
      repeat (20) @(posedge clk);
      chk(32'(we_cnt), 32'h10);
      acc(1'h0, ADDR_START, 32'h0, 32'h0, 1'h0);
      acc(1'h0, ADDR_PATTERN, 32'h0, 32'h0000FFFF, 1'h0);
      acc(1'h0, 19'h20010, 32'h0, 32'h0, 1'h0);
   endtask : t_fill

   // near-miss key must not start anything
   task automatic t_badkey;
      we_cnt = 0;
      acc(1'h1, ADDR_START, 32'h31415927, 32'h0, 1'h0);
      acc(1'h0, ADDR_START, 32'h0, 32'h0, 1'h0);
      repeat (4) @(posedge clk);
      chk(32'(we_cnt), 32'h0);
   endtask : t_badkey

   // reset in the middle of a host fill restarts the power-up pass with a cleared pattern
   task automatic t_rerun;
      acc(1'h1, ADDR_PATTERN, 32'h5A5A5A5A, 32'h0, 1'h0);
      exp_pat = 32'h5A5A5A5A;
      acc(1'h1, ADDR_START, START_KEY, 32'h0, 1'h0);
      repeat (3) @(posedge clk);
      #1;
      reset     = 1'h1;
      fill_left = 16;
      grp_exp   = 4'h0;
      exp_pat   = PATTERN_RESET;
      we_cnt    = 0;
      @(posedge clk) #1;
      chk({31'h0, tdm_hiz}, 32'h1);
      chk(cm_wdata, PATTERN_RESET);
      @(posedge clk) #1;
      reset = 1'h0;
      acc(1'h0, ADDR_START, 32'h0, 32'h3, 1'h0);
      acc(1'h0, ADDR_PATTERN, 32'h0, PATTERN_RESET, 1'h0);
      repeat (20) @(posedge clk);
      chk(32'(we_cnt), 32'h10);
      acc(1'h0, ADDR_START, 32'h0, 32'h0, 1'h0);
   endtask : t_rerun
   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end

   initial begin
      reset = 1'h1;
      repeat (8) @(posedge clk);
      #1 reset = 1'h0;
      t_powerup();
      t_fill();
      t_badkey();
      t_rerun();
      summarize();
   end
endmodule : testbench
